/* psi_illum_sync.sv */
`timescale 1ns/100ps
`include "psi_map.svh"
// Operation
// R01: Up to three illumination channels, each with its own enable output.
// R02: Each channel drives a PWM output whose duty sets LED current.
// R03: All enables can be held off so an outside processor switches illumination.
// R04: Alive_blink_out output toggles continuously while the system runs correctly.
// R05: Fault indicator lit in normal operation, off whenever a fault exists.
// R06: First trigger advances one pattern or alternates two, per mode.
// R07: Second trigger pauses the sequence or advances it by two, per mode; pause acts in internal timing only, advance by two in external mode only.
// R08: Outside processor drives triggers when it wants patterns shown.
// R09: First trigger output high exactly during each pattern exposure.
// R10: Second trigger output high while the first pattern is shown.
// R11: All timing comes from one reference clock.
// R12: Trigger inputs synchronised; one edge acted on per event.
// R13: Trigger mode configurable, latched before the next sequence starts.
module psi_illum_sync
  import psi_pkg::*;
#(
  parameter int          NCH       = `PSI_NUM_CH,
  parameter int          PW        = `PSI_PWM_BITS,
  parameter int          SW        = `PSI_SEQ_BITS,
  parameter int unsigned BEAT_HALF = `PSI_BEAT_HALF
) (
  // Clock and reset
  input  wire logic                clk, // R11
  input  wire logic                rst,
  // Configuration
  input  wire logic [NCH-1:0]      illum_ch_select,
  input  wire logic                illum_external_ctrl,
  input  wire logic [NCH*PW-1:0]   illum_duty,
  input  wire psi_trig_mode_t      trig_mode,
  input  wire logic                ext_trigger_mode,
  input  wire logic [SW-1:0]       seq_length,
  input  wire logic [15:0]         expose_cycles,
  input  wire logic [15:0]         gap_cycles,
  input  wire logic                seq_start,
  input  wire logic                seq_stop,
  input  wire logic                system_fault,
  // Trigger inputs
  input  wire logic                pattern_advance_in,
  input  wire logic                pattern_pause_in,
  // Illumination outputs
  output logic                     illum_ch0_enable,
  output logic                     illum_ch1_enable,
  output logic                     illum_ch2_enable,
  output logic                     illum_ch0_current_pwm,
  output logic                     illum_ch1_current_pwm,
  output logic                     illum_ch2_current_pwm,
  // Indicators
  output logic                     alive_blink_out,
  output logic                     fault_led_out,
  // Sync outputs
  output logic                     exposure_active_out,
  output logic                     first_pattern_out,
  output logic [SW-1:0]            pattern_index_q,
  output logic                     seq_running_q
);

  // ==========================================================
  // Trigger synchronisers
  // ==========================================================
  logic adv_rise;
  logic pause_rise;

  // Pins settle in two flops, then one pulse per rise
  psi_edge_sync u_adv_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (pattern_advance_in),
    .rise (adv_rise)
  );

  psi_edge_sync u_pause_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (pattern_pause_in),
    .rise (pause_rise)
  );

  // ==========================================================
  // Current PWM, one per channel
  // ==========================================================
  logic [NCH-1:0] pwm_raw;

  // Channel duty slices, ch0 in the low byte
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_pwm
      psi_pwm #(.W(PW)) u_pwm (
        .clk   (clk),
        .rst   (rst),
        .duty  (illum_duty[g*PW +: PW]),
        .pwm_q (pwm_raw[g])
      );
    end
  endgenerate

  // ==========================================================
  // Pattern sequencer
  // ==========================================================
  psi_state_t     state_q;
  psi_trig_mode_t mode_q;
  logic [15:0]    tmr_q;
  logic           paused_q;
  logic           alt_q;

  function automatic logic [SW-1:0] wrap_add(input logic [SW-1:0] idx,
                                             input logic [SW-1:0] step,
                                             input logic [SW-1:0] len);
    logic [SW:0] s;
    s = {1'b0, idx} + {1'b0, step};
    // Zero length keeps the index at zero
    if (len == '0) begin
      wrap_add = '0;
    end else if (s >= {1'b0, len}) begin
      wrap_add = SW'(s - {1'b0, len});
    end else begin
      wrap_add = s[SW-1:0];
    end
  endfunction

  logic           start_ok;
  logic           go_next;
  logic [SW-1:0]  step;

  // A start while running is ignored
  assign start_ok = seq_start & ~seq_running_q;

  // Decide when and how far to advance after an exposure
  // External mode acts only in a gap; edges during exposure drop
  always_comb begin
    go_next = 1'b0;
    step    = SW'(1);
    if (ext_trigger_mode) begin // R08
      if (adv_rise) begin
        go_next = 1'b1;
        // Alternating mode steps forward one, then back one
        step    = mode_q.advance_alt ? (alt_q ? SW'(seq_length - 1'b1) : SW'(1))
                                     : SW'(1); // R06
      end else if (pause_rise && mode_q.pause_by_two) begin
        go_next = 1'b1;
        step    = SW'(2); // R07
      end
    end else begin
      go_next = (tmr_q == '0) && !paused_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= '0;
    end else if (start_ok) begin
      // Mode held for the whole sequence
      mode_q <= trig_mode; // R13
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      paused_q <= 1'b0;
    end else if (start_ok) begin
      paused_q <= 1'b0;
    end else if (pause_rise && !mode_q.pause_by_two && seq_running_q) begin
      // One-step mode pause halts internal timing only
      paused_q <= ~paused_q; // R07
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q         <= PSI_ST_IDLE;
      tmr_q           <= '0;
      pattern_index_q <= '0;
      seq_running_q   <= 1'b0;
      alt_q           <= 1'b0;
    end else begin
      case (state_q)
        PSI_ST_IDLE: begin
          if (start_ok) begin
            state_q         <= PSI_ST_EXPOSE;
            tmr_q           <= expose_cycles;
            pattern_index_q <= '0;
            alt_q           <= 1'b0;
            seq_running_q   <= 1'b1;
          end
        end
        PSI_ST_EXPOSE: begin
          // Stop wins over timer and triggers
          if (seq_stop) begin
            state_q       <= PSI_ST_IDLE;
            seq_running_q <= 1'b0;
          end else if (tmr_q != '0) begin
            tmr_q <= tmr_q - 16'h0001;
          end else begin
            state_q <= PSI_ST_GAP;
            tmr_q   <= gap_cycles;
          end
        end
        PSI_ST_GAP: begin
          // Internal mode waits out the gap, external waits for an edge
          if (seq_stop) begin
            state_q       <= PSI_ST_IDLE;
            seq_running_q <= 1'b0;
          end else if (!ext_trigger_mode && tmr_q != '0) begin
            tmr_q <= tmr_q - 16'h0001;
          end else if (go_next) begin
            state_q         <= PSI_ST_EXPOSE;
            tmr_q           <= expose_cycles;
            alt_q           <= ~alt_q;
            pattern_index_q <= wrap_add(pattern_index_q, step, seq_length); // R06
          end
        end
        default: begin
          state_q       <= PSI_ST_IDLE;
          seq_running_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Exposure decode
  // ==========================================================
  logic expo_d;
  logic first_d;

  // A stop cuts exposure, enables and first flag on one edge
  assign expo_d  = (state_q == PSI_ST_EXPOSE) && !seq_stop; // R09
  assign first_d = expo_d && (pattern_index_q == '0); // R10

  // ==========================================================
  // Sync outputs
  // ==========================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exposure_active_out <= 1'b0;
      first_pattern_out   <= 1'b0;
    end else begin
      exposure_active_out <= expo_d; // R09
      first_pattern_out   <= first_d; // R10
    end
  end

  // ==========================================================
  // Illumination outputs
  // ==========================================================
  logic [NCH-1:0] en_d;

  // Enables follow exposure unless handed to the outside processor
  always_comb begin
    en_d = illum_external_ctrl ? '0 // R03
         : (illum_ch_select & {NCH{expo_d}}); // R01
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      illum_ch0_enable      <= 1'b0;
      illum_ch1_enable      <= 1'b0;
      illum_ch2_enable      <= 1'b0;
      illum_ch0_current_pwm <= 1'b0;
      illum_ch1_current_pwm <= 1'b0;
      illum_ch2_current_pwm <= 1'b0;
    end else begin
      illum_ch0_enable      <= en_d[0]; // R01
      illum_ch1_enable      <= en_d[1];
      illum_ch2_enable      <= en_d[2];
      illum_ch0_current_pwm <= pwm_raw[0]; // R02
      illum_ch1_current_pwm <= pwm_raw[1];
      illum_ch2_current_pwm <= pwm_raw[2];
    end
  end

  // ==========================================================
  // Indicators
  // ==========================================================
  // Alive_blink_out freezes while a fault is present
  logic [31:0] beat_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      beat_q          <= '0;
      alive_blink_out <= 1'b0;
    end else if (system_fault) begin
      beat_q <= '0;
    end else if (beat_q >= BEAT_HALF - 1) begin
      beat_q          <= '0;
      alive_blink_out <= ~alive_blink_out; // R04
    end else begin
      beat_q <= beat_q + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_led_out <= 1'b0;
    end else begin
      // Lit while healthy, dark on fault
      fault_led_out <= ~system_fault; // R05
    end
  end

endmodule

/* psi_map.svh */
`ifndef PSI_MAP_SVH
`define PSI_MAP_SVH

`define PSI_NUM_CH        3
`define PSI_REF_CLK_KHZ   32000
`define PSI_CLK_KHZ       10000
`define PSI_BEAT_HALF     5000000
`define PSI_PWM_BITS      8
`define PSI_SEQ_BITS      8
`define PSI_SEQ_LEN_RST   8'h08
`define PSI_EXPO_CYC_RST  16'h03e8
`define PSI_GAP_CYC_RST   16'h0064

`endif

/* psi_pkg.sv */
package psi_pkg;
  typedef enum logic [1:0] {
    PSI_ST_IDLE,
    PSI_ST_EXPOSE,
    PSI_ST_GAP
  } psi_state_t;

  typedef struct packed {
    logic       advance_alt;
    logic       pause_by_two;
  } psi_trig_mode_t;

  typedef struct packed {
    logic [2:0] enable;
    logic [2:0] pwm;
  } psi_illum_t;
endpackage

/* psi_edge_sync.sv */
`timescale 1ns/100ps
module psi_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous level in, rising edge pulse out
  input  wire logic din,
  output logic      rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q & ~s3_q; // R12
endmodule

/* psi_pwm.sv */
`timescale 1ns/100ps
`include "psi_map.svh"
module psi_pwm
  import psi_pkg::*;
#(
  parameter int W = `PSI_PWM_BITS
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Duty and output
  input  wire logic [W-1:0] duty,
  output logic              pwm_q
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      pwm_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      pwm_q <= (cnt_q < duty); // R02
    end
  end
endmodule

/* psi_illum_sync_assertions.sv */
`timescale 1ns/100ps
`include "psi_map.svh"
module psi_illum_sync_chk
  import psi_pkg::*;
#(
  parameter int unsigned BEAT_HALF = `PSI_BEAT_HALF
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Inputs watched
  input wire logic        illum_external_ctrl,
  input wire logic        system_fault,
  input wire logic        seq_stop,
  input wire logic [15:0] expose_cycles,
  // Outputs watched
  input wire logic        illum_ch0_enable,
  input wire logic        illum_ch1_enable,
  input wire logic        illum_ch2_enable,
  input wire logic        alive_blink_out,
  input wire logic        fault_led_out,
  input wire logic        exposure_active_out,
  input wire logic        first_pattern_out,
  input wire logic [7:0]  pattern_index_q,
  input wire logic        seq_running_q
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [31:0] beat_q;
  logic [16:0] expo_q;
  logic        any_en;
  assign any_en = illum_ch0_enable | illum_ch1_enable | illum_ch2_enable;
  // Cycles since the blink moved, restarted by a fault
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      beat_q <= '0;
    end else if ($changed(alive_blink_out) || system_fault) begin
      beat_q <= '0;
    end else begin
      beat_q <= beat_q + 32'h1;
    end
  end
  // Length of the current exposure
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      expo_q <= '0;
    end else begin
      expo_q <= exposure_active_out ? expo_q + 17'h1 : '0;
    end
  end
  sequence start_seen;
    !seq_running_q ##1 seq_running_q;
  endsequence
  sequence first_expo;
    exposure_active_out && first_pattern_out && pattern_index_q == 8'h00;
  endsequence
  a_ext_ctrl_dark: assert property ($past(illum_external_ctrl) |-> !any_en)
    else $error("enable high under external control");
  a_en_in_expo: assert property (any_en |-> exposure_active_out)
    else $error("enable outside exposure");
  a_fault_led_follow: assert property (!$past(rst)
    |-> fault_led_out == !$past(system_fault))
    else $error("fault indicator wrong");
  a_first_in_expo: assert property (first_pattern_out |-> exposure_active_out)
    else $error("first pattern outside exposure");
  a_start_first_expo: assert property (start_seen |=> first_expo)
    else $error("start did not expose first pattern");
  a_expo_span: assert property ($fell(exposure_active_out) && !$past(seq_stop)
    |-> expo_q == {1'b0, expose_cycles} + 17'h1)
    else $error("exposure length wrong");
  a_blink_spacing: assert property ($changed(alive_blink_out) |-> beat_q >= BEAT_HALF - 2)
    else $error("blink too fast");
  a_blink_alive: assert property (beat_q <= BEAT_HALF + 1)
    else $error("blink stalled");
  a_fault_freeze: assert property ($past(system_fault) && $past(system_fault, 2)
    |-> $stable(alive_blink_out))
    else $error("blink moved during fault");
endmodule
bind psi_illum_sync psi_illum_sync_chk #(.BEAT_HALF(BEAT_HALF)) u_chk (.*);

/* psi_trig_host.sv */
`timescale 1ns/100ps
module psi_trig_host (
  // Clock
  input  wire logic clk,
  // Requests from the bench
  input  wire logic adv_req,
  input  wire logic pause_req,
  // Trigger lines
  output logic      pattern_advance_in,
  output logic      pattern_pause_in
);
  logic [2:0] adv_q = 3'h0;
  logic [2:0] pse_q = 3'h0;
  // Processor pulses a line for 4 cycles per wanted pattern
  always_ff @(negedge clk) begin
    adv_q <= adv_req ? 3'h4 : adv_q - {2'h0, adv_q != 3'h0};
    pse_q <= pause_req ? 3'h4 : pse_q - {2'h0, pse_q != 3'h0};
  end
  assign pattern_advance_in = adv_q != 3'h0;
  assign pattern_pause_in   = pse_q != 3'h0;
endmodule

/* tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import psi_pkg::*;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic [2:0]     sel = 3'h5;
  logic           ext_ctrl = 1'b0;
  logic [23:0]    duty = 24'hff_40_00;
  psi_trig_mode_t mode = '0;
  logic           ext_mode = 1'b0;
  logic           start = 1'b0;
  logic           stop = 1'b0;
  logic           fault = 1'b0;
  logic           adv_req = 1'b0;
  logic           pause_req = 1'b0;
  logic           adv, pse, en0, en1, en2, pw0, pw1, pw2, blink, fled, expo, first, run;
  logic [7:0]     idx;
  logic [7:0]     held;
  int             errors = 0;
  int             total_checks = 0;
  int             cyc = 0;
  int             k, n0, n1, n2;
  always #50 clk = ~clk;
  psi_illum_sync #(.BEAT_HALF(4)) dut (.clk(clk), .rst(rst), .illum_ch_select(sel),
    .illum_external_ctrl(ext_ctrl), .illum_duty(duty), .trig_mode(mode),
    .ext_trigger_mode(ext_mode), .seq_length(8'h04), .expose_cycles(16'h0003),
    .gap_cycles(16'h0002), .seq_start(start), .seq_stop(stop), .system_fault(fault),
    .pattern_advance_in(adv), .pattern_pause_in(pse), .illum_ch0_enable(en0),
    .illum_ch1_enable(en1), .illum_ch2_enable(en2), .illum_ch0_current_pwm(pw0),
    .illum_ch1_current_pwm(pw1), .illum_ch2_current_pwm(pw2), .alive_blink_out(blink),
    .fault_led_out(fled), .exposure_active_out(expo), .first_pattern_out(first),
    .pattern_index_q(idx), .seq_running_q(run));
  psi_trig_host u_host (.clk(clk), .adv_req(adv_req), .pause_req(pause_req),
    .pattern_advance_in(adv), .pattern_pause_in(pse));
  task close_out();
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  task cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task seq_go();
    start = 1'b1;
    cyc_n(1);
    start = 1'b0;
    cyc_n(2);
    `CHK("expo", 1'b1, expo)
    `CHK("first", 1'b1, first)
    `CHK("en", ext_ctrl ? 3'h0 : sel, {en2, en1, en0})
    `CHK("run", 1'b1, run)
  endtask
  task seq_end();
    stop = 1'b1;
    cyc_n(1);
    stop = 1'b0;
    cyc_n(4);
    `CHK("run", 1'b0, run)
    `CHK("expo_off", 1'b0, expo)
    `CHK("en_off", 3'h0, {en2, en1, en0})
  endtask
  task trig(input logic p, input logic [7:0] want);
    if (p) pause_req <= 1'b1;
    else adv_req <= 1'b1;
    cyc_n(1);
    pause_req <= 1'b0;
    adv_req <= 1'b0;
    cyc_n(14);
    `CHK("index", want, idx)
  endtask
  task s_internal();
    seq_go();
    for (k = 1; k <= 4; k++) begin
      while (expo !== 1'b0) cyc_n(1);
      while (expo !== 1'b1) cyc_n(1);
      `CHK("step", k[7:0] % 8'h04, idx)
      `CHK("first", k == 4, first)
    end
    trig(1'b1, 8'h00);
    cyc_n(30);
    `CHK("paused", 8'h00, idx)
    trig(1'b1, 8'h02);
    seq_end();
  endtask
  task s_ext_ctrl();
    ext_ctrl = 1'b1;
    seq_go();
    seq_end();
    ext_ctrl = 1'b0;
  endtask
  task s_external();
    ext_mode = 1'b1;
    sel = 3'h2;
    seq_go();
    cyc_n(10);
    trig(1'b0, 8'h01);
    mode.advance_alt = 1'b1;
    trig(1'b0, 8'h02);
    seq_end();
    seq_go();
    trig(1'b0, 8'h01);
    trig(1'b0, 8'h00);
    seq_end();
    mode = '{advance_alt: 1'b0, pause_by_two: 1'b1};
    seq_go();
    trig(1'b1, 8'h02);
    trig(1'b1, 8'h00);
    seq_end();
    ext_mode = 1'b0;
    mode = '0;
    sel = 3'h5;
  endtask
  task s_pwm();
    n0 = 0;
    n1 = 0;
    n2 = 0;
    repeat (256) begin
      cyc_n(1);
      n0 += int'(pw0 === 1'b1);
      n1 += int'(pw1 === 1'b1);
      n2 += int'(pw2 === 1'b1);
    end
    `CHK("pwm0", 0, n0)
    `CHK("pwm1", 64, n1)
    `CHK("pwm2", 255, n2)
  endtask
  task s_fault();
    fault = 1'b1;
    cyc_n(2);
    `CHK("fault_led", 1'b0, fled)
    held[0] = blink;
    cyc_n(12);
    `CHK("frozen", held[0], blink)
    fault = 1'b0;
    cyc_n(10);
    `CHK("fault_led", 1'b1, fled)
    n0 = 0;
    repeat (16) begin
      held[0] = blink;
      cyc_n(1);
      n0 += int'(blink !== held[0]);
    end
    `CHK("blinks", 4, n0)
  endtask
  initial begin
    cyc_n(10);
    rst = 1'b0;
    cyc_n(2);
    `CHK("fault_led", 1'b1, fled)
    `CHK("idle", 1'b0, expo)
    s_internal();
    s_ext_ctrl();
    s_external();
    s_pwm();
    s_fault();
    close_out();
  end
endmodule
